// ---- hw/pfr_irq_flags.sv ----
// Peripheral interrupt request flag registers three and four with mask and interrupt line.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - All flag bits readable, writable, hardware-set, reset zero.
// - Oscillator failure sets top bit, register three.
// - Completed clock switch sets switch-done flag.
// - Timer three gate going inactive sets flag.
// - Timer three overflow sets flag; software clears.
// - Logic cell conditions set bits three..zero.
// - Waveform generator shutdowns set register four top bits.
// - Timer five gate closing sets its flag.
// - Timer five overflow sets flag; software clears.
// - Capture mode: each capture sets unit flag.
// - Compare mode: each match sets unit flag.
// - PWM mode: output trailing edge sets flag.
// - Flags set regardless of enable masks.
module pfr_irq_flags
  import pfr_pkg::*;
#(
  parameter int N_CELLS = NUM_CELLS,
  parameter int N_CAPCMP = NUM_CAPCMP
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DATA_W-1:0] regRdata,
  // Peripheral event strobes
  input wire pfr_events_t evt,
  input wire pfr_capcmp_t [N_CAPCMP-1:0] capcmp,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Elaboration checks
  if (N_CELLS != NUM_CELLS) begin : g_bad_cells
    $error("pfr_irq_flags: logic cell count must be four");
  end
  if (N_CAPCMP != NUM_CAPCMP) begin : g_bad_capcmp
    $error("pfr_irq_flags: capture/compare unit count must be four");
  end

  // ==========================================================================
  // Declarations
  pfr_bus_req_t req;
  pfr_regs_t st_r;
  pfr_regs_t st_nxt;
  logic [DATA_W-1:0] set3;
  logic [DATA_W-1:0] set4;
  logic [DATA_W-1:0] flags3;
  logic [DATA_W-1:0] flags4;
  logic [N_CAPCMP-1:0] ccSet;
  logic wr3;
  logic wr4;

  assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};
  assign wr3 = req.wr && (req.addr == FLAGS3_OFS);
  assign wr4 = req.wr && (req.addr == FLAGS4_OFS);

  // ==========================================================================
  // Event to flag mapping; no mask takes part here.
  always_comb begin
    set3 = '0;
    set3[OSC_FAIL_BIT] = evt.oscFail;
    set3[CLK_SW_BIT] = evt.clkSwitchDone;
    set3[T3_GATE_BIT] = evt.timer3Gate;
    set3[T3_OVF_BIT] = evt.timer3Ovf;
    set3[CELL_LO_BIT +: NUM_CELLS] = evt.logicCell;
  end

  // A unit's strobe only counts when it matches the unit's current mode.
  always_comb begin
    for (int u = 0; u < N_CAPCMP; u++) begin
      case (capcmp[u].mode)
        MODE_CAPTURE: ccSet[u] = capcmp[u].capture;
        MODE_COMPARE: ccSet[u] = capcmp[u].compare;
        MODE_PWM: ccSet[u] = capcmp[u].pwmFall;
        default: ccSet[u] = 1'b0;
      endcase
    end
  end

  always_comb begin
    set4 = '0;
    set4[WG2_BIT] = evt.wavegenShutdown[1];
    set4[WG1_BIT] = evt.wavegenShutdown[0];
    set4[T5_GATE_BIT] = evt.timer5Gate;
    set4[T5_OVF_BIT] = evt.timer5Ovf;
    set4[CC_LO_BIT +: NUM_CAPCMP] = ccSet;
  end

  // ==========================================================================
  // Flag bits; set wins over a write in the same cycle.
  generate
    for (genvar b = 0; b < DATA_W; b++) begin : g_bit
      pfr_flag_cell #(
        .RST_VAL(FLAGS_RST[b])
      ) u_f3 (
        .mclk(mclk),
        .nrst(nrst),
        .hwSet(set3[b]),
        .wrEn(wr3),
        .wrData(req.wdata[b]),
        .flag(flags3[b])
      );
      pfr_flag_cell #(
        .RST_VAL(FLAGS_RST[b])
      ) u_f4 (
        .mclk(mclk),
        .nrst(nrst),
        .hwSet(set4[b]),
        .wrEn(wr4),
        .wrData(req.wdata[b]),
        .flag(flags4[b])
      );
    end
  endgenerate

  // ==========================================================================
  // Masks, read data and interrupt line.
  always_comb begin
    st_nxt = st_r;
    if (req.wr && (req.addr == MASK3_OFS)) begin
      st_nxt.mask3 = req.wdata;
    end
    if (req.wr && (req.addr == MASK4_OFS)) begin
      st_nxt.mask4 = req.wdata;
    end
    st_nxt.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        FLAGS3_OFS: st_nxt.rdata = flags3;
        FLAGS4_OFS: st_nxt.rdata = flags4;
        MASK3_OFS: st_nxt.rdata = st_r.mask3;
        MASK4_OFS: st_nxt.rdata = st_r.mask4;
        default: st_nxt.rdata = '0;
      endcase
    end
    st_nxt.irq = |((flags3 & st_r.mask3) | (flags4 & st_r.mask4));
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r.mask3 <= MASK_RST;
      st_r.mask4 <= MASK_RST;
      st_r.rdata <= '0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdata = st_r.rdata;
  assign irq = st_r.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  property p_reset_clear;
    @(posedge mclk) disable iff (1'b0)
      !nrst |=> (flags3 == FLAGS_RST) && (flags4 == FLAGS_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not cleared by reset");

  property p_sw_write;
    wr3 && (set3 == '0) |=> flags3 == $past(req.wdata);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("written value not stored in register three");

  property p_osc_fail;
    evt.oscFail |=> flags3[OSC_FAIL_BIT];
  endproperty
  a_osc_fail: assert property (p_osc_fail)
    else $error("oscillator failure did not set its flag");

  property p_clk_switch;
    evt.clkSwitchDone |=> flags3[CLK_SW_BIT];
  endproperty
  a_clk_switch: assert property (p_clk_switch)
    else $error("clock switch completion did not set its flag");

  property p_t3_gate;
    evt.timer3Gate |=> flags3[T3_GATE_BIT];
  endproperty
  a_t3_gate: assert property (p_t3_gate)
    else $error("timer three gate event did not set its flag");

  property p_t3_ovf_hold;
    flags3[T3_OVF_BIT] && !wr3 |=> flags3[T3_OVF_BIT];
  endproperty
  a_t3_ovf_hold: assert property (p_t3_ovf_hold)
    else $error("timer three overflow flag cleared without a write");

  property p_t3_ovf_set;
    evt.timer3Ovf |=> flags3[T3_OVF_BIT];
  endproperty
  a_t3_ovf_set: assert property (p_t3_ovf_set)
    else $error("timer three overflow did not set its flag");

  property p_cells;
    |evt.logicCell |=>
      (flags3[CELL_LO_BIT +: NUM_CELLS] & $past(evt.logicCell)) == $past(evt.logicCell);
  endproperty
  a_cells: assert property (p_cells)
    else $error("logic cell event did not set its flag");

  property p_wavegen;
    evt.wavegenShutdown[1] |=> flags4[WG2_BIT];
  endproperty
  a_wavegen: assert property (p_wavegen)
    else $error("second waveform generator shutdown did not set its flag");

  property p_wavegen_one;
    evt.wavegenShutdown[0] |=> flags4[WG1_BIT];
  endproperty
  a_wavegen_one: assert property (p_wavegen_one)
    else $error("first waveform generator shutdown did not set its flag");

  property p_t5_gate;
    evt.timer5Gate |=> flags4[T5_GATE_BIT];
  endproperty
  a_t5_gate: assert property (p_t5_gate)
    else $error("timer five gate event did not set its flag");

  property p_t5_ovf_hold;
    flags4[T5_OVF_BIT] && !wr4 |=> flags4[T5_OVF_BIT];
  endproperty
  a_t5_ovf_hold: assert property (p_t5_ovf_hold)
    else $error("timer five overflow flag cleared without a write");

  property p_capture;
    (capcmp[3].mode == MODE_CAPTURE) && capcmp[3].capture |=> flags4[CC_LO_BIT + 3];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not set unit four flag");

  property p_compare;
    (capcmp[2].mode == MODE_COMPARE) && capcmp[2].compare |=> flags4[CC_LO_BIT + 2];
  endproperty
  a_compare: assert property (p_compare)
    else $error("compare match did not set unit three flag");

  property p_pwm_gate;
    (capcmp[3].mode == MODE_PWM) && capcmp[3].capture && !capcmp[3].pwmFall
      && !flags4[CC_LO_BIT + 3] && !wr4 |=> !flags4[CC_LO_BIT + 3];
  endproperty
  a_pwm_gate: assert property (p_pwm_gate)
    else $error("capture strobe set flag while unit is in pwm mode");

  property p_pwm;
    (capcmp[2].mode == MODE_PWM) && capcmp[2].pwmFall |=> flags4[CC_LO_BIT + 2];
  endproperty
  a_pwm: assert property (p_pwm)
    else $error("pwm trailing edge did not set unit three flag");

  property p_no_mask_needed;
    (st_r.mask3 == '0) && (st_r.mask4 == '0) && evt.timer5Ovf |=>
      flags4[T5_OVF_BIT] && !irq;
  endproperty
  a_no_mask_needed: assert property (p_no_mask_needed)
    else $error("masked event failed to set flag or raised interrupt");

  property p_irq_follow;
    ((flags3 & st_r.mask3) != '0) && !wr3 && $stable(st_r.mask3) |=> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("unmasked flag did not raise interrupt");

  property p_set_wins;
    wr3 && !req.wdata[OSC_FAIL_BIT] && evt.oscFail |=> flags3[OSC_FAIL_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("hardware set lost against software clear");

  property p_set_wins4;
    wr4 && !req.wdata[T5_OVF_BIT] && evt.timer5Ovf |=> flags4[T5_OVF_BIT];
  endproperty
  a_set_wins4: assert property (p_set_wins4)
    else $error("timer five overflow lost against software clear");

  property p_read_data;
    req.rd && (req.addr == FLAGS4_OFS) |=> regRdata == $past(flags4);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data of register four wrong");

  c_irq_rise: cover property ($rose(irq));
  c_collision: cover property (wr3 && (req.wdata == '0) && (set3 != '0));
  c_capture: cover property ((capcmp[3].mode == MODE_CAPTURE) && capcmp[3].capture);
  c_pwm_edge: cover property ((capcmp[2].mode == MODE_PWM) && capcmp[2].pwmFall);

endmodule

`default_nettype wire

// ---- hw/pfr_pkg.sv ----
// Shared constants and carrier types for the peripheral interrupt flag registers.
`default_nettype none

package pfr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] FLAGS3_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] FLAGS4_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] MASK3_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] MASK4_OFS = 4'h3;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;

  // ==========================================================================
  // Field positions of the clock, timer three and logic cell register
  localparam int OSC_FAIL_BIT = 7;
  localparam int CLK_SW_BIT = 6;
  localparam int T3_GATE_BIT = 5;
  localparam int T3_OVF_BIT = 4;
  localparam int CELL_LO_BIT = 0;

  // ==========================================================================
  // Field positions of the waveform, timer five and capture register
  localparam int WG2_BIT = 7;
  localparam int WG1_BIT = 6;
  localparam int T5_GATE_BIT = 5;
  localparam int T5_OVF_BIT = 4;
  localparam int CC_LO_BIT = 0;

  // ==========================================================================
  // Peripheral counts
  localparam int NUM_CELLS = 4;
  localparam int NUM_WAVEGEN = 2;
  localparam int NUM_CAPCMP = 4;

  // ==========================================================================
  // Capture/compare unit mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_COMPARE = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfr_bus_req_t;

  typedef struct packed {
    logic oscFail;
    logic clkSwitchDone;
    logic timer3Gate;
    logic timer3Ovf;
    logic [NUM_CELLS-1:0] logicCell;
    logic [NUM_WAVEGEN-1:0] wavegenShutdown;
    logic timer5Gate;
    logic timer5Ovf;
  } pfr_events_t;

  typedef struct packed {
    logic [1:0] mode;
    logic capture;
    logic compare;
    logic pwmFall;
  } pfr_capcmp_t;

  typedef struct packed {
    logic [DATA_W-1:0] mask3;
    logic [DATA_W-1:0] mask4;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } pfr_regs_t;

  typedef struct packed {
    logic flag;
  } pfr_cell_t;

endpackage

`default_nettype wire

// ---- hw/pfr_flag_cell.sv ----
// One hardware-set, software-writable interrupt flag bit.
`timescale 1ns/100ps
`default_nettype none

module pfr_flag_cell
  import pfr_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Hardware event and software write
  input wire logic hwSet,
  input wire logic wrEn,
  input wire logic wrData,
  // Flag
  output logic flag
);

  pfr_cell_t st_r;
  pfr_cell_t st_nxt;

  // ==========================================================================
  // Next state: a hardware set overrides a write of zero in the same cycle.
  always_comb begin
    st_nxt = st_r;
    if (wrEn) begin
      st_nxt.flag = wrData;
    end
    if (hwSet) begin
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r.flag <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;

endmodule

`default_nettype wire

// ---- test/pfr_irq_flags_test.sv ----
// Self-checking testbench for the peripheral interrupt flag registers.
`timescale 1ns/100ps
`default_nettype none

module pfr_irq_flags_test
  import pfr_pkg::*;
;
  // ==========================================================================
  // Stimulus and expected values
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdata;
  pfr_events_t evt = '0;
  pfr_capcmp_t [NUM_CAPCMP-1:0] capcmp = '0;
  logic irq;
  logic [DATA_W-1:0] f3 = '0, f4 = '0, m3 = '0, m4 = '0, expRd = '0;
  logic expIrq = 1'b0;
  logic armed = 1'b0;
  int num_errors = 0;
  int checks = 0;

  pfr_irq_flags dut_u (
    .mclk(mclk),
    .nrst(nrst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .evt(evt),
    .capcmp(capcmp),
    .irq(irq)
  );

  initial begin
    forever #10 mclk = ~mclk;
  end

  // ==========================================================================
  // Reference model
  function automatic logic [DATA_W-1:0] ev3f(input pfr_events_t e);
    return {e.oscFail, e.clkSwitchDone, e.timer3Gate, e.timer3Ovf, e.logicCell};
  endfunction

  function automatic logic [DATA_W-1:0] ev4f(input pfr_events_t e,
                                             input pfr_capcmp_t [NUM_CAPCMP-1:0] c);
    logic [NUM_CAPCMP-1:0] hit;
    for (int i = 0; i < NUM_CAPCMP; i++) begin
      hit[i] = (c[i].mode == MODE_CAPTURE && c[i].capture) ||
               (c[i].mode == MODE_COMPARE && c[i].compare) ||
               (c[i].mode == MODE_PWM && c[i].pwmFall);
    end
    return {e.wavegenShutdown, e.timer5Gate, e.timer5Ovf, hit};
  endfunction

  function automatic logic [DATA_W-1:0] rdf(input logic [ADDR_W-1:0] a);
    case (a)
      FLAGS3_OFS: return f3;
      FLAGS4_OFS: return f4;
      MASK3_OFS: return m3;
      MASK4_OFS: return m4;
      default: return 8'h00;
    endcase
  endfunction

  always @(posedge mclk) begin
    if (!nrst) begin
      armed <= 1'b1;
      f3 <= FLAGS_RST;
      f4 <= FLAGS_RST;
      m3 <= MASK_RST;
      m4 <= MASK_RST;
      expRd <= 8'h00;
      expIrq <= 1'b0;
    end else begin
      f3 <= ((regWr && regAddr == FLAGS3_OFS) ? regWdata : f3) | ev3f(evt);
      f4 <= ((regWr && regAddr == FLAGS4_OFS) ? regWdata : f4) | ev4f(evt, capcmp);
      m3 <= (regWr && regAddr == MASK3_OFS) ? regWdata : m3;
      m4 <= (regWr && regAddr == MASK4_OFS) ? regWdata : m4;
      expRd <= regRd ? rdf(regAddr) : 8'h00;
      expIrq <= |((f3 & m3) | (f4 & m4));
    end
  end

  always @(negedge mclk) begin
    if (armed) begin
      checks++;
      if (regRdata !== expRd) begin
        num_errors++;
        $display("BAD regRdata expected %h seen %h", expRd, regRdata);
      end
      checks++;
      if (irq !== expIrq) begin
        num_errors++;
        $display("BAD irq expected %b seen %b", expIrq, irq);
      end
    end
  end

  // ==========================================================================
  // Bus and event drivers
  task automatic cyc(input logic wr, input logic rd, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input pfr_events_t e,
                     input pfr_capcmp_t [NUM_CAPCMP-1:0] c);
    @(posedge mclk);
    regWr <= wr;
    regRd <= rd;
    regAddr <= a;
    regWdata <= d;
    evt <= e;
    capcmp <= c;
  endtask

  task automatic wrr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cyc(1'b1, 1'b0, a, d, '0, '0);
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    cyc(1'b0, 1'b1, a, 8'h00, '0, '0);
  endtask

  task automatic rdall();
    for (int a = 0; a < 5; a++) begin
      rdr((a == 4) ? 4'hf : ADDR_W'(a));
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("BAD run length expected finish seen timeout");
    end_sim();
  end

  // ==========================================================================
  // Tests
  initial begin
    pfr_capcmp_t [NUM_CAPCMP-1:0] c;
    logic [1:0] op;
    void'($urandom(84745));
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rdall();
    $display("test reset_values done");

    for (int i = 0; i < 12; i++) begin
      cyc(1'b0, 1'b0, 4'h0, 8'h00, pfr_events_t'(12'h001 << i), '0);
      rdr(FLAGS3_OFS);
      rdr(FLAGS4_OFS);
      wrr(FLAGS3_OFS, 8'h00);
      wrr(FLAGS4_OFS, 8'h00);
    end
    $display("test event_flags done");

    for (int u = 0; u < NUM_CAPCMP; u++) begin
      for (int m = 0; m < 4; m++) begin
        for (int k = 0; k < 3; k++) begin
          c = '0;
          c[u].mode = 2'(m);
          c[u].capture = (k == 0);
          c[u].compare = (k == 1);
          c[u].pwmFall = (k == 2);
          cyc(1'b0, 1'b0, 4'h0, 8'h00, '0, c);
          rdr(FLAGS4_OFS);
          wrr(FLAGS4_OFS, 8'h00);
        end
      end
    end
    $display("test capcmp_modes done");

    for (int i = 0; i < 8; i++) begin
      wrr(ADDR_W'(i), 8'($urandom));
      rdr(ADDR_W'(i));
    end
    wrr(4'h9, 8'hff);
    rdall();
    $display("test write_readback done");

    wrr(FLAGS3_OFS, 8'h00);
    cyc(1'b1, 1'b0, FLAGS3_OFS, 8'h00, pfr_events_t'(12'h900), '0);
    cyc(1'b0, 1'b1, FLAGS3_OFS, 8'h00, '0, '0);
    rdr(FLAGS3_OFS);
    wrr(FLAGS4_OFS, 8'h00);
    cyc(1'b1, 1'b0, FLAGS4_OFS, 8'h00, pfr_events_t'(12'h001), '0);
    rdr(FLAGS4_OFS);
    $display("test set_beats_clear done");

    wrr(MASK3_OFS, 8'h00);
    wrr(MASK4_OFS, 8'h00);
    wrr(FLAGS3_OFS, 8'h00);
    wrr(FLAGS4_OFS, 8'h00);
    cyc(1'b0, 1'b0, 4'h0, 8'h00, pfr_events_t'(12'h004), '0);
    rdr(FLAGS4_OFS);
    wrr(MASK4_OFS, 8'h40);
    repeat (3) rdr(FLAGS4_OFS);
    wrr(FLAGS4_OFS, 8'h00);
    rdr(MASK4_OFS);
    wrr(MASK3_OFS, 8'h80);
    cyc(1'b0, 1'b0, 4'h0, 8'h00, pfr_events_t'(12'h800), '0);
    repeat (3) rdr(FLAGS3_OFS);
    $display("test mask_irq done");

    for (int n = 0; n < 400; n++) begin
      op = 2'($urandom % 3);
      for (int u = 0; u < NUM_CAPCMP; u++) begin
        c[u] = pfr_capcmp_t'(5'($urandom));
      end
      cyc(op == 2'h1, op == 2'h2, ADDR_W'($urandom), 8'($urandom),
          pfr_events_t'(12'($urandom & $urandom & $urandom)), c);
    end
    cyc(1'b0, 1'b0, 4'h0, 8'h00, '0, '0);
    rdall();
    $display("test random_mix done");

    cyc(1'b0, 1'b0, 4'h0, 8'h00, '0, '0);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rdall();
    cyc(1'b0, 1'b0, 4'h0, 8'h00, '0, '0);
    $display("test mid_reset done");
    end_sim();
  end
endmodule

`default_nettype wire
